// ==== sspc_top.sv ====
// Serial channel with enable and stop control behind an APB slave
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sspc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic irq
);
    // ==========================================================
    // Declarations
    sspc_pkg::sspc_ctrl_t ctl_q, ctl_d;
    logic [7:0] baud_q, baud_d, txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
    logic [7:0] gpio_q, gpio_d;
    logic [2:0] ist_q, ist_d, imsk_q, imsk_d, iev;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic [3:0] s1_q, s2_q;
    logic sclk_prev_q;
    logic [7:0] dcnt_q, dcnt_d;
    logic ph_q, ph_d, h;
    sspc_pkg::sspc_tx_t tst_q, tst_d;
    logic [9:0] tsr_q, tsr_d;
    logic [3:0] tcnt_q, tcnt_d;
    logic tbe_q, tbe_d, tsc_q, tsc_d, pend_q, pend_d, sclk_q, sclk_d;
    sspc_pkg::sspc_rx_t rst_q, rst_d;
    logic [7:0] rsr_q, rsr_d, rdiv_q, rdiv_d;
    logic [3:0] rcnt_q, rcnt_d;
    logic [4:0] rhc_q, rhc_d, hcn;
    logic rfull_q, rfull_d, rdone;
    sspc_pkg::sspc_pins_t pin_q, pin_d;
    logic [3:0] chan_o, chan_oe;
    logic setup, wr, rd, tx_run, rx_run, ext, fall_ev, rise_ev, tx_en_rise;

    // Exact offset match, shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // Any implemented register
    function automatic logic mapped(input logic [7:0] a);
        return hit(a, sspc_pkg::A_CTRL) | hit(a, sspc_pkg::A_TXBUF) |
            hit(a, sspc_pkg::A_RXBUF) | hit(a, sspc_pkg::A_STAT) |
            hit(a, sspc_pkg::A_ISTAT) | hit(a, sspc_pkg::A_IMASK) |
            hit(a, sspc_pkg::A_BAUD) | hit(a, sspc_pkg::A_GPIO) |
            hit(a, sspc_pkg::A_PIN);
    endfunction

    // ==========================================================
    // Shared strobes and mode terms
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready_q & pwrite;
    assign rd = psel & penable & pready_q & ~pwrite;
    assign ext = ctl_q.sync & ctl_q.ext_clk;
    // Sync transmit clock also serves reception, so channel enable holds it
    assign tx_run = ctl_q.sync ? (ctl_q.tx_en | ctl_q.chan_en)
                               : ctl_q.tx_en;
    assign rx_run = ctl_q.sync ? (ctl_q.rx_en & ctl_q.chan_en)
                               : ctl_q.rx_en;
    // One clock for both directions: fall shifts out, rise samples in
    assign fall_ev = ext ? (sclk_prev_q & ~s2_q[sspc_pkg::P_SCLK])
                         : (h & ph_q);
    assign rise_ev = ext ? (~sclk_prev_q & s2_q[sspc_pkg::P_SCLK])
                         : (h & ~ph_q);
    assign tx_en_rise = wr & hit(paddr, sspc_pkg::A_CTRL) &
                        pwdata[sspc_pkg::TX_EN_BIT] & ~ctl_q.tx_en;

    // ==========================================================
    // Pin input synchroniser, second stage alone feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 4'hF;
            s2_q <= 4'hF;
            sclk_prev_q <= 1'b1;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            sclk_prev_q <= s2_q[sspc_pkg::P_SCLK];
        end
    end

    // ==========================================================
    // APB registers; set of a status flag wins over its clear
    always_comb begin
        ctl_d = ctl_q;
        baud_d = baud_q;
        gpio_d = gpio_q;
        imsk_d = imsk_q;
        ist_d = ist_q;
        prdata_d = prdata_q;
        pready_d = setup;
        pslverr_d = setup & ~mapped(paddr);
        if (setup) begin
            prdata_d = 32'h0000_0000;
            if (hit(paddr, sspc_pkg::A_CTRL))
                prdata_d[6:0] = ctl_q;
            if (hit(paddr, sspc_pkg::A_RXBUF))
                prdata_d[7:0] = rxbuf_q;
            if (hit(paddr, sspc_pkg::A_STAT))
                prdata_d[4:0] = {rst_q == sspc_pkg::RX_BUSY,
                    tst_q == sspc_pkg::TX_SHIFT, rfull_q, tsc_q, tbe_q};
            if (hit(paddr, sspc_pkg::A_ISTAT))
                prdata_d[2:0] = ist_q;
            if (hit(paddr, sspc_pkg::A_IMASK))
                prdata_d[2:0] = imsk_q;
            if (hit(paddr, sspc_pkg::A_BAUD))
                prdata_d[7:0] = baud_q;
            if (hit(paddr, sspc_pkg::A_GPIO))
                prdata_d[7:0] = gpio_q;
            if (hit(paddr, sspc_pkg::A_PIN))
                prdata_d[3:0] = s2_q;
        end
        if (wr) begin
            if (hit(paddr, sspc_pkg::A_CTRL))
                ctl_d = pwdata[6:0];
            if (hit(paddr, sspc_pkg::A_BAUD))
                baud_d = pwdata[7:0];
            if (hit(paddr, sspc_pkg::A_GPIO))
                gpio_d = pwdata[7:0];
            if (hit(paddr, sspc_pkg::A_IMASK))
                imsk_d = pwdata[2:0];
            if (hit(paddr, sspc_pkg::A_ISTAT))
                ist_d = ist_q & ~pwdata[2:0];
        end
        ist_d = ist_d | iev;
        irq_d = |(ist_q & imsk_q);
    end

    // Register stage for bus and configuration state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= sspc_pkg::CTRL_RST;
            baud_q <= sspc_pkg::BAUD_RST;
            gpio_q <= sspc_pkg::GPIO_RST;
            imsk_q <= 3'h0;
            ist_q <= 3'h0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            baud_q <= baud_d;
            gpio_q <= gpio_d;
            imsk_q <= imsk_d;
            ist_q <= ist_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // ==========================================================
    // Half-bit divider; idle and cleared while transmitter is stopped
    assign h = tx_run & (dcnt_q == baud_q);
    always_comb begin
        dcnt_d = 8'h00;
        ph_d = 1'b0;
        if (tx_run) begin
            dcnt_d = h ? 8'h00 : dcnt_q + 8'h01;
            ph_d = h ? ~ph_q : ph_q;
        end
    end

    // Divider registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcnt_q <= 8'h00;
            ph_q <= 1'b0;
        end else begin
            dcnt_q <= dcnt_d;
            ph_q <= ph_d;
        end
    end

    // ==========================================================
    // Transmitter; shifts on transmit enable without channel enable, pins decide
    always_comb begin
        tst_d = tst_q;
        tsr_d = tsr_q;
        tcnt_d = tcnt_q;
        tbe_d = tbe_q;
        tsc_d = tsc_q;
        pend_d = pend_q;
        sclk_d = sclk_q;
        txbuf_d = txbuf_q;
        if (!tx_run) begin
            tst_d = sspc_pkg::TX_IDLE;
            tsr_d = 10'h3FF;
            pend_d = 1'b0;
            sclk_d = 1'b1;
        end else begin
            if (rise_ev) begin
                sclk_d = 1'b1;
                if (pend_q) begin
                    tsc_d = 1'b0;
                    pend_d = 1'b0;
                end
            end
            if (fall_ev) begin
                if (tst_q == sspc_pkg::TX_SHIFT && tcnt_q != 4'h1) begin
                    tsr_d = {1'b1, tsr_q[9:1]};
                    tcnt_d = tcnt_q - 4'h1;
                    sclk_d = ~ctl_q.sync;
                end else if (!tbe_q) begin
                    // Load on empty shifter, channel enable not needed
                    tst_d = sspc_pkg::TX_SHIFT;
                    tsr_d = ctl_q.sync ? {2'b11, txbuf_q}
                                       : {1'b1, txbuf_q, 1'b0};
                    tcnt_d = ctl_q.sync ? sspc_pkg::TX_SYNC_BITS
                                        : sspc_pkg::TX_ASYNC_BITS;
                    tbe_d = 1'b1;
                    pend_d = 1'b1;
                    sclk_d = ~ctl_q.sync;
                end else begin
                    tst_d = sspc_pkg::TX_IDLE;
                    tsr_d = 10'h3FF;
                    tsc_d = 1'b1;
                end
            end
        end
        if (wr && hit(paddr, sspc_pkg::A_TXBUF)) begin
            txbuf_d = pwdata[7:0];
            tbe_d = 1'b0;
        end
        if (tx_en_rise) begin
            tbe_d = 1'b1;
            tsc_d = 1'b1;
        end
    end

    // Transmit interrupt from the selected flag, forced by enable
    always_comb begin
        iev = 3'h0;
        iev[sspc_pkg::I_TX] = tx_en_rise | (ctl_q.tx_irq_sel ?
            (tsc_d & ~tsc_q) : (tbe_d & ~tbe_q));
        iev[sspc_pkg::I_RX] = rdone;
        iev[sspc_pkg::I_OVR] = rdone & rfull_q;
    end

    // Transmitter registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tst_q <= sspc_pkg::TX_IDLE;
            tsr_q <= 10'h3FF;
            tcnt_q <= 4'h0;
            tbe_q <= 1'b1;
            tsc_q <= 1'b1;
            pend_q <= 1'b0;
            sclk_q <= 1'b1;
            txbuf_q <= 8'h00;
        end else begin
            tst_q <= tst_d;
            tsr_q <= tsr_d;
            tcnt_q <= tcnt_d;
            tbe_q <= tbe_d;
            tsc_q <= tsc_d;
            pend_q <= pend_d;
            sclk_q <= sclk_d;
            txbuf_q <= txbuf_d;
        end
    end

    // ==========================================================
    // Receiver: sync samples on the shared clock, async on own timer
    assign hcn = rhc_q + 5'h01;
    always_comb begin
        rst_d = rst_q;
        rsr_d = rsr_q;
        rcnt_d = rcnt_q;
        rdiv_d = rdiv_q;
        rhc_d = rhc_q;
        rxbuf_d = rxbuf_q;
        rdone = 1'b0;
        if (!rx_run) begin
            rst_d = sspc_pkg::RX_IDLE;
            rcnt_d = 4'h0;
        end else if (ctl_q.sync) begin
            rst_d = sspc_pkg::RX_IDLE;
            // Sampling rides the transmit clock of the same frame
            if (rise_ev && tst_q == sspc_pkg::TX_SHIFT) begin
                rsr_d = {s2_q[sspc_pkg::P_RXD], rsr_q[7:1]};
                rcnt_d = rcnt_q + 4'h1;
                if (rcnt_q == sspc_pkg::RX_SYNC_LAST) begin
                    rcnt_d = 4'h0;
                    rxbuf_d = rsr_d;
                    rdone = 1'b1;
                end
            end
        end else begin
            case (rst_q)
                sspc_pkg::RX_IDLE: begin
                    if (!s2_q[sspc_pkg::P_RXD]) begin
                        rst_d = sspc_pkg::RX_BUSY;
                        rdiv_d = 8'h00;
                        rhc_d = 5'h00;
                    end
                end
                sspc_pkg::RX_BUSY: begin
                    rdiv_d = rdiv_q + 8'h01;
                    if (rdiv_q == baud_q) begin
                        rdiv_d = 8'h00;
                        rhc_d = hcn;
                        if (hcn == sspc_pkg::HC_START) begin
                            if (s2_q[sspc_pkg::P_RXD])
                                rst_d = sspc_pkg::RX_IDLE;
                        end else if (hcn == sspc_pkg::HC_STOP) begin
                            rst_d = sspc_pkg::RX_IDLE;
                            rxbuf_d = rsr_q;
                            rdone = 1'b1;
                        end else if (hcn[0]) begin
                            rsr_d = {s2_q[sspc_pkg::P_RXD], rsr_q[7:1]};
                        end
                    end
                end
                default: rst_d = sspc_pkg::RX_IDLE;
            endcase
        end
        // A new byte wins over a read in the same cycle
        rfull_d = (rfull_q & ~(rd & hit(paddr, sspc_pkg::A_RXBUF))) | rdone;
    end

    // Receiver registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_q <= sspc_pkg::RX_IDLE;
            rsr_q <= 8'h00;
            rcnt_q <= 4'h0;
            rdiv_q <= 8'h00;
            rhc_q <= 5'h00;
            rxbuf_q <= 8'h00;
            rfull_q <= 1'b0;
        end else begin
            rst_q <= rst_d;
            rsr_q <= rsr_d;
            rcnt_q <= rcnt_d;
            rdiv_q <= rdiv_d;
            rhc_q <= rhc_d;
            rxbuf_q <= rxbuf_d;
            rfull_q <= rfull_d;
        end
    end

    // ==========================================================
    // Pin ownership; shift register output is live on channel enable
    always_comb begin
        chan_o = 4'h0;
        chan_oe = 4'h0;
        chan_o[sspc_pkg::P_TXD] = tsr_q[0];
        chan_oe[sspc_pkg::P_TXD] = 1'b1;
        chan_o[sspc_pkg::P_SCLK] = sclk_q;
        chan_oe[sspc_pkg::P_SCLK] = ctl_q.sync & ~ctl_q.ext_clk;
        // Ready is low-active and needs the transmit side enabled too
        chan_o[sspc_pkg::P_RDY] = rfull_q;
        chan_oe[sspc_pkg::P_RDY] = ctl_q.sync & ctl_q.rdy_en &
            ctl_q.rx_en & ctl_q.tx_en;
    end

    // Per-pin select between serial function and general port
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign pin_d.o[gi] = ctl_q.chan_en ? chan_o[gi]
                                               : gpio_q[gi];
            assign pin_d.oe[gi] = ctl_q.chan_en ? chan_oe[gi]
                                                : gpio_q[gi + 4];
        end
    endgenerate

    // Pin output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pin_q <= '0;
        else
            pin_q <= pin_d;
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = pin_q.o;
    assign pin_oe = pin_q.oe;
    assign irq = irq_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pins_gpio_own: assert property (!ctl_q.chan_en |=>
        pin_oe == $past(gpio_q[7:4]) && pin_out == $past(gpio_q[3:0]))
        else $error("pins not general I/O while channel off");
    a_tx_pin_live: assert property (ctl_q.chan_en |=>
        pin_out[sspc_pkg::P_TXD] == $past(tsr_q[0]))
        else $error("transmit pin does not follow shifter");
    a_enable_flags: assert property (tx_en_rise |=>
        tbe_q && tsc_q ##1 ist_q[sspc_pkg::I_TX])
        else $error("transmit enable did not set flags");
    a_async_tx_stop: assert property (!ctl_q.sync && !ctl_q.tx_en
        |=> tst_q == sspc_pkg::TX_IDLE && tsr_q == 10'h3FF)
        else $error("async transmitter not stopped");
    a_rx_stop: assert property (!rx_run |=>
        rst_q == sspc_pkg::RX_IDLE && rcnt_q == 4'h0 && !rdone)
        else $error("receiver still running");
    a_sync_keep_tx: assert property (ctl_q.sync && ctl_q.chan_en &&
        tst_q == sspc_pkg::TX_SHIFT && !fall_ev
        |=> tst_q == sspc_pkg::TX_SHIFT)
        else $error("sync transmitter stopped with channel on");
    a_chan_keep_tx: assert property (ctl_q.tx_en && !ctl_q.chan_en &&
        tst_q == sspc_pkg::TX_SHIFT && tcnt_q > 4'h1
        |=> tst_q == sspc_pkg::TX_SHIFT)
        else $error("channel disable halted transmission");
    a_load_empty: assert property (tx_run && !tbe_q && fall_ev &&
        tst_q == sspc_pkg::TX_IDLE && !(wr && hit(paddr, sspc_pkg::A_TXBUF))
        |=> tst_q == sspc_pkg::TX_SHIFT && tbe_q)
        else $error("buffer not moved to shifter");
    a_tsc_fall: assert property ($fell(tsc_q) |-> $past(rise_ev) &&
        $past(pend_q)) else $error("complete flag fell off half clock");
    a_rdy_enables: assert property ($rose(pin_oe[sspc_pkg::P_RDY]) &&
        $past(ctl_q.chan_en) |->
        $past(ctl_q.rx_en & ctl_q.tx_en & ctl_q.rdy_en))
        else $error("ready output without all enables");
endmodule

// ==== sspc_pkg.sv ====
// Constants, fields and types of the serial port enable and stop control
package sspc_pkg;
    // ==========================================================
    // Register byte offsets on the APB side
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TXBUF = 8'h04;
    localparam logic [7:0] A_RXBUF = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_ISTAT = 8'h10;
    localparam logic [7:0] A_IMASK = 8'h14;
    localparam logic [7:0] A_BAUD = 8'h18;
    localparam logic [7:0] A_GPIO = 8'h1C;
    localparam logic [7:0] A_PIN = 8'h20;
    // ==========================================================
    // Control register layout, bit 6 first
    typedef struct packed {
        logic tx_irq_sel;
        logic rdy_en;
        logic ext_clk;
        logic sync;
        logic rx_en;
        logic tx_en;
        logic chan_en;
    } sspc_ctrl_t;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam int TX_EN_BIT = 1;
    localparam logic [7:0] BAUD_RST = 8'h0F;
    localparam logic [7:0] GPIO_RST = 8'h00;
    // ==========================================================
    // Interrupt bits and pin indexes
    localparam int I_TX = 0;
    localparam int I_RX = 1;
    localparam int I_OVR = 2;
    localparam int P_TXD = 0;
    localparam int P_RXD = 1;
    localparam int P_SCLK = 2;
    localparam int P_RDY = 3;
    // ==========================================================
    // Frame lengths and async sampling points in half bits
    localparam logic [3:0] TX_ASYNC_BITS = 4'hA;
    localparam logic [3:0] TX_SYNC_BITS = 4'h8;
    localparam logic [3:0] RX_SYNC_LAST = 4'h7;
    localparam logic [4:0] HC_START = 5'h01;
    localparam logic [4:0] HC_STOP = 5'h13;
    // ==========================================================
    // State machines and pin bundle
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} sspc_tx_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} sspc_rx_t;
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] o;
    } sspc_pins_t;
endpackage

// ==== sspc_peer.sv ====
// Serial partner model on the transmit, receive, clock and ready pins
`timescale 1ns/1ps
module sspc_peer (
    input wire logic pclk,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_in
);
    logic [3:0] drv = 4'hF; // Peer levels, idle high as pulled up
    logic [7:0] got = 8'h00;
    // ==========================================================
    // Wire level
    // The enabled driver wins, else the peer level or pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : drv[i];
        end
    end
    // Async frame into the receive pin, bit time in pclk cycles
    task automatic send_async(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            drv[1] <= f[i];
            repeat (bt - 1) @(posedge pclk);
        end
    endtask
    // Async frame off the transmit pin, sampled mid-bit
    task automatic get_async(input int bt);
        @(negedge pin_in[0]);
        repeat (bt + bt / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = pin_in[0];
            repeat (bt) @(posedge pclk);
        end
    endtask
    // Own shift clock for both directions, stands still between frames
    task automatic sync_frame(input logic [7:0] b);
        @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            drv[2] <= 1'b0;
            drv[1] <= b[i];
            repeat (4) @(posedge pclk);
            drv[2] <= 1'b1;
            repeat (4) @(posedge pclk);
            got[i] = pin_in[0]; // Late in the bit, txd lags the edge
        end
        drv[1] <= ~b[7]; // Released line shows no stale bit
    endtask
endmodule

// ==== tb_serial_port_enable_stop_control.sv ====
// Testbench for the serial port enable and stop control block
`timescale 1ns/1ps
module tb_serial_port_enable_stop_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slv_err;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic irq;
    int num_errors = 0;
    int check_count = 0;
    sspc_top sspc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    sspc_peer sspc_peer_inst (.pclk(pclk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));
    initial begin
        forever #20 pclk = ~pclk;
    end
    // ==========================================================
    // Bus and check tasks
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input string nm);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(nm, r & m, e);
    endtask
    // Whole control word cleared before it is rewritten
    task automatic set_ctrl(input logic [31:0] v);
        wr(sspc_pkg::A_CTRL, 32'h0);
        wr(sspc_pkg::A_CTRL, v);
    endtask
    // Poll the busy flag; bounded so a stuck shifter still ends
    task automatic wait_idle();
        logic [31:0] r;
        int n;
        n = 0;
        r = 32'h8;
        while (r[3] !== 1'b0 && n < 300) begin
            apb(1'b0, sspc_pkg::A_STAT, 32'h0, r);
            n++;
        end
        check("tx idle", {31'h0, r[3]}, 32'h0);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog, far beyond the expected run
    initial begin
        #2000000;
        num_errors++;
        close_out();
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(sspc_pkg::A_CTRL, 32'hFF, 32'h00, "ctrl reset");
        rd_chk(sspc_pkg::A_BAUD, 32'hFF, 32'h0F, "baud reset");
        rd_chk(sspc_pkg::A_STAT, 32'h1F, 32'h03, "stat reset");
        rd_chk(8'h3C, 32'hFFFFFFFF, 32'h0, "unmapped read");
        check("slverr", {31'h0, slv_err}, 32'h1);
        // Enabling transmit raises flags and the request, then mask/clear
        wr(sspc_pkg::A_BAUD, 32'h3); // Bit time 8 pclk
        wr(sspc_pkg::A_IMASK, 32'h1);
        set_ctrl(32'h03);
        rd_chk(sspc_pkg::A_STAT, 32'h3, 32'h3, "tbe tsc");
        rd_chk(sspc_pkg::A_ISTAT, 32'h1, 32'h1, "tx req");
        check("irq on", {31'h0, irq}, 32'h1);
        wr(sspc_pkg::A_IMASK, 32'h0);
        rd_chk(sspc_pkg::A_IMASK, 32'h7, 32'h0, "mask");
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(sspc_pkg::A_ISTAT, 32'h1);
        rd_chk(sspc_pkg::A_ISTAT, 32'h1, 32'h0, "tx req clr");
        // Async frame on the pin, complete flag timing
        fork
            sspc_peer_inst.get_async(8);
            begin
                wr(sspc_pkg::A_TXBUF, 32'hA5);
                rd_chk(sspc_pkg::A_STAT, 32'h2, 32'h2, "tsc early");
                repeat (8) @(posedge pclk);
                rd_chk(sspc_pkg::A_STAT, 32'h2, 32'h0, "tsc late");
            end
        join
        check("tx byte", {24'h0, sspc_peer_inst.got}, 32'hA5);
        wait_idle();
        // Channel off, transmitter on: pins stay general I/O
        wr(sspc_pkg::A_GPIO, 32'h5A);
        set_ctrl(32'h02);
        wr(sspc_pkg::A_TXBUF, 32'h3C);
        repeat (30) begin
            @(posedge pclk);
            #1;
            check("gpio pins", {24'h0, pin_oe, pin_out & pin_oe},
                  32'h50);
        end
        rd_chk(sspc_pkg::A_STAT, 32'h8, 32'h8, "hidden shift");
        wr(sspc_pkg::A_CTRL, 32'h03);
        @(posedge pclk);
        #1;
        check("txd driven", {31'h0, pin_oe[0]}, 32'h1);
        rd_chk(sspc_pkg::A_STAT, 32'h8, 32'h8, "still busy");
        wait_idle();
        // Async reception on, transmit off; then reception off
        set_ctrl(32'h05);
        wr(sspc_pkg::A_TXBUF, 32'h77);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_STAT, 32'h8, 32'h0, "tx stopped");
        sspc_peer_inst.send_async(8'h96, 8);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_RXBUF, 32'hFF, 32'h96, "rx byte");
        set_ctrl(32'h03);
        sspc_peer_inst.send_async(8'h11, 8);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_STAT, 32'h4, 32'h0, "rx stopped");
        wait_idle();
        // Sync mode: transmit enable alone does not stop the shifter
        set_ctrl(32'h0D);
        wr(sspc_pkg::A_TXBUF, 32'h55);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_STAT, 32'h8, 32'h8, "sync tx runs");
        wait_idle();
        rd_chk(sspc_pkg::A_RXBUF, 32'hFF, 32'hFF, "sync rx on");
        set_ctrl(32'h08);
        wr(sspc_pkg::A_TXBUF, 32'h55);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_STAT, 32'h8, 32'h0, "sync halted");
        set_ctrl(32'h0E);
        wr(sspc_pkg::A_TXBUF, 32'h66);
        wait_idle();
        rd_chk(sspc_pkg::A_STAT, 32'h4, 32'h0, "sync rx off");
        // External shift clock, full duplex, ready output
        set_ctrl(32'h3F);
        @(posedge pclk);
        #1;
        check("rdy pin", {30'h0, pin_oe[3], pin_out[3]}, 32'h2);
        wr(sspc_pkg::A_TXBUF, 32'h3C);
        repeat (10) @(posedge pclk);
        sspc_peer_inst.sync_frame(8'hC3);
        check("sync tx", {24'h0, sspc_peer_inst.got}, 32'h3C);
        repeat (10) @(posedge pclk);
        rd_chk(sspc_pkg::A_RXBUF, 32'hFF, 32'hC3, "sync rx");
        close_out();
    end
endmodule
